// ---- src/predrv_status_pkg.sv ----
/*
 * shared constants and types for the predriver status readout block.
 * assumes an spi mode 0 link sampled by the 100 mhz time-base clock.
 */
package predrv_status_pkg;

  // command codes (upper bits) and field positions
  localparam logic [2:0] CMD_STATUS_READ  = 3'h0;
  localparam logic [2:0] CMD_IRQ_EN       = 3'h1;
  localparam logic [2:0] CMD_MODE         = 3'h2;
  localparam logic [2:0] CMD_FLAG_CLEAR   = 3'h3;
  localparam logic [2:0] CMD_DEADTIME     = 3'h4;
  localparam int         GROUP_BIT        = 4;
  localparam int         MODE_LOCK_BIT    = 0;
  localparam int         MODE_FULL_ON_MODE_BIT  = 1;
  localparam int         MODE_DESATURATION_DETECT_BIT   = 3;

  // status selection codes (low two bits)
  localparam logic [1:0] SEL_FAULT_LATCH  = 2'h0;
  localparam logic [1:0] SEL_MODE_BITS    = 2'h1;
  localparam logic [1:0] SEL_IRQ_ENABLES  = 2'h2;
  localparam logic [1:0] SEL_DEADTIME     = 2'h3;

  // fault latch bit positions
  localparam int FLT_OVERTEMP   = 0;
  localparam int FLT_DESATURATION_DETECT      = 1;
  localparam int FLT_LOW_SUPPLY = 2;
  localparam int FLT_OVERCUR    = 3;
  localparam int FLT_PHASE      = 4;
  localparam int FLT_FRAMING    = 5;
  localparam int FLT_WRITE      = 6;
  localparam int FLT_RESET_EVT  = 7;

  // reset values
  localparam logic [7:0] FAULT_LATCH_RST  = 8'h80;
  localparam logic [7:0] MODE_BITS_RST    = 8'h00;
  localparam logic [3:0] IRQ_GROUP_RST    = 4'hf;
  localparam logic [7:0] DEADTIME_RST     = 8'h00;
  localparam logic [7:0] APPLIED_DT_RST   = 8'hff;

  // timing
  localparam int DESATURATION_DETECT_BLANK_NS = 1000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DESATURATION_DETECT_BLANK_CYC =
    (DESATURATION_DETECT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_DIV_SHIFT  = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_CAL  = 3'b100
  } link_state_t;

endpackage

// ---- src/phase_monitor.sv ----
/*
 * per-phase error monitor: one generate slice per phase.
 * assumes drive commands and synchronised switch-node levels on i_mclk.
 */
`timescale 1ns/10ps
module phase_monitor (
  input  wire logic                 i_mclk,
  input  wire logic                 i_srst,
  input  wire logic [2:0]           i_hs_on,
  input  wire logic [2:0]           i_ls_on,
  input  wire logic [2:0]           i_node_high,
  input  wire logic [7:0]           i_deadtime,
  input  wire logic                 i_full_on,
  output logic      [2:0]           o_phase_err
);
  import predrv_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      typedef struct packed {
        logic [9:0] cnt;
        logic       prev_hs;
        logic       prev_ls;
        logic       err;
      } mon_t;
      mon_t mon_reg;
      mon_t mon_next;
      logic one_on;

      // exactly one driver of the phase enabled
      assign one_on = i_hs_on[g] ^ i_ls_on[g];

      // timer restarts on each turn-on, error checked after deadtime and blanking
      always_comb begin
        mon_next = mon_reg;
        mon_next.prev_hs = i_hs_on[g];
        mon_next.prev_ls = i_ls_on[g];
        mon_next.err = 1'b0;
        if ((i_hs_on[g] && !mon_reg.prev_hs) || (i_ls_on[g] && !mon_reg.prev_ls)) begin
          mon_next.cnt = 10'h000;
        end else if (mon_reg.cnt != 10'h3ff) begin
          mon_next.cnt = mon_reg.cnt + 10'h001;
        end
        if (one_on && !i_full_on && (mon_reg.cnt >= 10'(DESATURATION_DETECT_BLANK_CYC))
            && (mon_reg.cnt >= {2'h0, i_deadtime})) begin
          // driver state xor node level: hs expects high, ls expects low
          mon_next.err = i_hs_on[g] ? !i_node_high[g] : i_node_high[g];
        end
        if (i_srst) begin
          mon_next = '0;
        end
      end

      always_ff @(posedge i_mclk) begin
        mon_reg <= mon_next;
      end

      assign o_phase_err[g] = mon_reg.err;
    end
  endgenerate

endmodule

// ---- src/predriver_status_readout.sv ----
/*
 * status readout and fault latching of a three-phase gate predriver.
 * every output is registered; only the status byte itself is buffered.
 * assumes spi mode 0 from the host (cs low active), sampled by i_mclk;
 * detector inputs are asynchronous levels from the analog front end.
 */
`timescale 1ns/10ps
module predriver_status_readout (
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_mosi,
  input  wire logic [2:0] i_overtemperature_detector,
  input  wire logic [2:0] i_desaturation_detect,
  input  wire logic       i_gate_supply_low,
  input  wire logic       i_overcurrent,
  input  wire logic [2:0] i_hs_on,
  input  wire logic [2:0] i_ls_on,
  input  wire logic [2:0] i_phase_switch_node,
  output logic            o_spi_miso,
  output logic            o_irq,
  output logic [7:0]      o_applied_deadtime,
  output logic            o_full_on_mode,
  output logic            o_desaturation_detect_ignore
);
  import predrv_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every asynchronous input
  localparam int SW = 3 + 3 + 3 + 2 + 3 + 3 + 3;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  always_ff @(posedge i_mclk) begin
    sync1_reg <= {i_spi_cs_n, i_spi_sclk, i_spi_mosi, i_overtemperature_detector,
                  i_desaturation_detect, i_gate_supply_low, i_overcurrent,
                  i_hs_on, i_ls_on, i_phase_switch_node};
    sync2_reg <= sync1_reg;
  end

  logic       cs_n;
  logic       sclk;
  logic       mosi;
  logic [2:0] otemp;
  logic [2:0] desaturation_detect;
  logic       low_sup;
  logic       ovc;
  logic [2:0] hs_on;
  logic [2:0] ls_on;
  logic [2:0] node_hi;
  // unpack the synchronised copies in the order they were packed
  assign cs_n    = sync2_reg[19];
  assign sclk    = sync2_reg[18];
  assign mosi    = sync2_reg[17];
  assign otemp   = sync2_reg[16:14];
  assign desaturation_detect   = sync2_reg[13:11];
  assign low_sup = sync2_reg[10];
  assign ovc     = sync2_reg[9];
  assign hs_on   = sync2_reg[8:6];
  assign ls_on   = sync2_reg[5:3];
  assign node_hi = sync2_reg[2:0];

  ////////////////////////////////////////////////////////////////////////
  // all block state
  typedef struct packed {
    link_state_t state;
    logic        prev_sclk;
    logic        prev_cs_n;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic [3:0]  bit_cnt;
    logic        frame_bad;
    logic [1:0]  sel;
    logic        cal_pending;
    logic        cal_sclk_seen;
    logic [12:0] cal_cnt;
    logic [7:0]  fault;
    logic        lock;
    logic        full_on;
    logic        desaturation_detect_mode;
    logic        dt_calibrated;
    logic        cal_overflow;
    logic        zero_dt;
    logic [3:0]  irq_en_a;
    logic [3:0]  irq_en_b;
    logic [7:0]  dt_status;
    logic [7:0]  dt_applied;
    logic        irq;
    logic        miso;
    logic        rst_evt_pend;
  } state_t;
  state_t st_reg;
  state_t st_next;

  logic [2:0] phase_err;
  logic [7:0] cond;
  logic [7:0] set_bits;
  logic [7:0] mode_stat;
  logic [7:0] cmd;
  logic       phase_any;
  logic [2:0] op;
  logic       frame_err;
  logic       is_read;
  logic       is_irq_en;
  logic       is_mode;
  logic       is_clear;
  logic       is_dt;
  logic       bad_code;
  logic       locked_wr;
  logic [7:0] clr_bits;
  logic [7:0] irq_mask;
  logic [7:0] status_sel;

  ////////////////////////////////////////////////////////////////////////
  // phase error monitors
  phase_monitor u_phase_monitor (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_hs_on     (hs_on),
    .i_ls_on     (ls_on),
    .i_node_high (node_hi),
    .i_deadtime  (st_reg.dt_applied),
    .i_full_on   (st_reg.full_on),
    .o_phase_err (phase_err)
  );

  // any phase reporting a high-side or low-side error
  assign phase_any = |phase_err;

  // live fault conditions feeding the latches
  always_comb begin
    cond = 8'h00;
    cond[FLT_OVERTEMP]   = |otemp;
    cond[FLT_DESATURATION_DETECT]      = (|desaturation_detect) | phase_any;
    cond[FLT_LOW_SUPPLY] = low_sup;
    cond[FLT_OVERCUR]    = ovc;
    cond[FLT_PHASE]      = phase_any;
  end

  // mode status word, bits 7 and 2 read zero
  always_comb begin
    mode_stat = MODE_BITS_RST;
    mode_stat[0] = st_reg.lock;
    mode_stat[1] = st_reg.full_on;
    mode_stat[3] = st_reg.dt_calibrated;
    mode_stat[4] = st_reg.cal_overflow;
    mode_stat[5] = st_reg.zero_dt;
    mode_stat[6] = st_reg.desaturation_detect_mode;
  end

  assign cmd = {st_reg.shift_in[6:0], mosi};

  ////////////////////////////////////////////////////////////////////////
  // decode of the last whole byte; a frame with no whole byte is bad
  always_comb begin
    op        = st_reg.shift_in[7:5];
    frame_err = st_reg.frame_bad || (st_reg.bit_cnt != 4'h0);
    is_read   = (op == CMD_STATUS_READ);
    is_irq_en = (op == CMD_IRQ_EN);
    is_mode   = (op == CMD_MODE);
    is_clear  = (op == CMD_FLAG_CLEAR);
    is_dt     = (op == CMD_DEADTIME);
    bad_code  = !(is_read || is_irq_en || is_mode || is_clear || is_dt);
    locked_wr = st_reg.lock && !is_read && !bad_code;
    clr_bits  = 8'h00;
    // group bit picks which nibble of the latch a clear addresses
    if (st_reg.shift_in[GROUP_BIT]) begin
      clr_bits[7:4] = st_reg.shift_in[3:0];
    end else begin
      clr_bits[3:0] = st_reg.shift_in[3:0];
    end
  end

  // enable word: group b high nibble, group a low nibble
  assign irq_mask = {st_reg.irq_en_b, st_reg.irq_en_a};

  // status byte offered at the next frame start
  always_comb begin
    case (st_reg.sel)
      SEL_MODE_BITS:   status_sel = mode_stat;
      SEL_IRQ_ENABLES: status_sel = irq_mask;
      SEL_DEADTIME:    status_sel = st_reg.dt_status;
      default:         status_sel = st_reg.fault;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // link state machine, command decode and fault latching
  always_comb begin
    // hold state by default; edge detectors follow the synchronised pins
    st_next = st_reg;
    set_bits = cond;
    st_next.prev_sclk = sclk;
    st_next.prev_cs_n = cs_n;
    st_next.rst_evt_pend = 1'b0;
    if (st_reg.rst_evt_pend) begin
      set_bits[FLT_RESET_EVT] = 1'b1;
    end
    case (st_reg.state)
      ST_IDLE: begin
        // frame start: measure a pulse or open a transfer
        if (st_reg.prev_cs_n && !cs_n) begin
          if (st_reg.cal_pending) begin
            st_next.state = ST_CAL;
            st_next.cal_cnt = 13'h0000;
            st_next.cal_sclk_seen = 1'b0;
          end else begin
            st_next.state = ST_XFER;
            st_next.bit_cnt = 4'h0;
            st_next.frame_bad = 1'b1; // no whole byte yet
            // capture selected status at frame start
            st_next.shift_out = status_sel;
            st_next.miso = st_next.shift_out[7];
          end
        end
      end

      ST_XFER: begin
        // sample mosi on each sclk rise, count the bits of the byte
        if (!st_reg.prev_sclk && sclk) begin
          st_next.shift_in = cmd;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == 4'h7) begin
            st_next.bit_cnt = 4'h0;
            st_next.frame_bad = 1'b0; // a whole byte has arrived
          end
        end
        // next reply bit after each sclk fall
        if (st_reg.prev_sclk && !sclk) begin
          st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
          st_next.miso = st_reg.shift_out[6];
        end
        // frame end: decode the last whole byte
        if (cs_n) begin
          st_next.state = ST_IDLE;
          st_next.miso = 1'b0;
          st_next.sel = SEL_FAULT_LATCH;
          if (frame_err) begin
            set_bits[FLT_FRAMING] = 1'b1;
          end else if (is_read) begin
            st_next.sel = st_reg.shift_in[1:0];
          end else if (locked_wr || bad_code) begin
            set_bits[FLT_WRITE] = 1'b1;
          end else if (is_clear) begin
            st_next.fault = st_reg.fault & ~clr_bits;
          end else if (is_irq_en) begin
            if (st_reg.shift_in[GROUP_BIT]) begin
              st_next.irq_en_b = st_reg.shift_in[3:0];
            end else begin
              st_next.irq_en_a = st_reg.shift_in[3:0];
            end
          end else if (is_mode) begin
            st_next.lock = st_reg.shift_in[MODE_LOCK_BIT];
            st_next.full_on = st_reg.shift_in[MODE_FULL_ON_MODE_BIT];
            st_next.desaturation_detect_mode = st_reg.shift_in[MODE_DESATURATION_DETECT_BIT];
          end else if (is_dt) begin
            if (st_reg.shift_in[0]) begin
              st_next.cal_pending = 1'b1;
            end else begin
              st_next.dt_applied = 8'h00;
              st_next.dt_status = 8'h00;
              st_next.zero_dt = 1'b1;
              st_next.cal_overflow = 1'b0;
              st_next.dt_calibrated = 1'b1;
            end
          end
        end
      end

      ST_CAL: begin
        // measure the calibration pulse; sclk must stay quiet meanwhile
        if (st_reg.cal_cnt != 13'h1fff) begin
          st_next.cal_cnt = st_reg.cal_cnt + 13'h0001;
        end
        if (st_reg.prev_sclk != sclk) begin
          st_next.cal_sclk_seen = 1'b1;
        end
        // pulse end: store count / 16, saturating on overflow
        if (cs_n) begin
          st_next.state = ST_IDLE;
          st_next.cal_pending = 1'b0;
          st_next.zero_dt = 1'b0;
          st_next.dt_calibrated = 1'b1;
          if (st_reg.cal_sclk_seen) begin
            set_bits[FLT_FRAMING] = 1'b1;
          end
          if (st_reg.cal_cnt[12]) begin
            st_next.cal_overflow = 1'b1;
            st_next.dt_applied = 8'hff;
            st_next.dt_status = 8'hff;
          end else begin
            st_next.cal_overflow = 1'b0;
            st_next.dt_applied = st_reg.cal_cnt[11:CAL_DIV_SHIFT];
            st_next.dt_status = st_reg.cal_cnt[11:CAL_DIV_SHIFT];
          end
        end
      end

      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
    // latch: set wins over clear, live condition holds flag
    st_next.fault = st_next.fault | set_bits;
    st_next.irq = |(st_reg.fault & irq_mask);
    // synchronous reset; the reset event is raised again a cycle later
    if (i_srst) begin
      st_next = '0;
      st_next.state = ST_IDLE;
      st_next.prev_cs_n = 1'b1;
      st_next.fault = FAULT_LATCH_RST;
      st_next.irq_en_a = IRQ_GROUP_RST;
      st_next.irq_en_b = IRQ_GROUP_RST;
      st_next.dt_status = DEADTIME_RST;
      st_next.dt_applied = APPLIED_DT_RST;
      st_next.rst_evt_pend = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state flops
  assign o_spi_miso         = st_reg.miso;
  assign o_irq              = st_reg.irq;
  assign o_applied_deadtime = st_reg.dt_applied;
  assign o_full_on_mode     = st_reg.full_on;
  assign o_desaturation_detect_ignore     = st_reg.desaturation_detect_mode;

endmodule

// ---- verif/predriver_status_readout_checker.sv ----
/* port-level timing properties of the predriver status readout.
   assumes the bind at the foot of this file attaches it to the design. */
`timescale 1ns/10ps
module predriver_status_readout_checker (
  input wire logic       i_mclk,
  input wire logic       i_srst,
  input wire logic       i_spi_cs_n,
  input wire logic       i_spi_sclk,
  input wire logic       o_spi_miso,
  input wire logic       o_irq,
  input wire logic [7:0] o_applied_deadtime,
  input wire logic       o_full_on_mode,
  input wire logic       o_desaturation_detect_ignore
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////
  // reset values and the reset-event interrupt
  AST_DT_AFTER_RST:
    assert property ($fell(i_srst) |-> o_applied_deadtime == 8'hff && !o_desaturation_detect_ignore)
    else $error("deadtime not at maximum after reset");
  AST_IRQ_AFTER_RST:
    assert property ($fell(i_srst) |-> ##[0:4] o_irq) else $error("no irq after reset");
  // serial reply framing
  AST_MISO_IDLE:
    assert property (i_spi_cs_n [*6] |-> !o_spi_miso) else $error("miso busy while idle");
  AST_MISO_HOLD:
    assert property (i_spi_sclk [*4] |-> $stable(o_spi_miso)) else $error("miso moved early");
  // settings only move at a command decode
  AST_DT_IN_FRAME:
    assert property ((!i_spi_cs_n) [*4] |-> $stable(o_applied_deadtime))
    else $error("deadtime moved inside a frame");
  AST_DT_AT_DECODE:
    assert property ($changed(o_applied_deadtime) |-> $past(i_spi_cs_n, 2))
    else $error("deadtime moved without decode");
  AST_MODE_AT_DECODE:
    assert property ($changed({o_full_on_mode, o_desaturation_detect_ignore}) |-> $past(i_spi_cs_n, 2))
    else $error("mode moved without decode");
  AST_IRQ_FALL:
    assert property ($fell(o_irq) |-> $past(i_spi_cs_n, 2)) else $error("irq fell unasked");
  // main scenarios reached
  cover property ($fell(o_irq));
  cover property ($changed(o_applied_deadtime));
  cover property ($rose(o_desaturation_detect_ignore));
endmodule
bind predriver_status_readout predriver_status_readout_checker u_checker (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk),
  .o_spi_miso(o_spi_miso), .o_irq(o_irq), .o_applied_deadtime(o_applied_deadtime),
  .o_full_on_mode(o_full_on_mode), .o_desaturation_detect_ignore(o_desaturation_detect_ignore));

// ---- verif/spi_host_model.sv ----
/* host model: spi mode 0 master with an 80 ns serial clock.
   assumes the device samples these lines with its own faster clock. */
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic i_miso,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_mosi
);
  // idle: deselected, serial clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  ////////////////////////////////////////
  // one frame of n bits, msb first; reply taken late in each high phase
  task automatic xfer(input logic [7:0] c, input int n, output logic [7:0] rsp);
    rsp = 8'h00;
    o_cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      o_mosi = c[7 - i];
      #40 o_sclk = 1'b1;
      #39 rsp = {rsp[6:0], i_miso};
      #1 o_sclk = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale bit
    #80;
  endtask
  // calibration pulse of n time-base periods, serial clock wiggled inside
  task automatic cal(input int n);
    o_cs_n = 1'b0;
    #(n * 5) o_sclk = 1'b1;
    #40 o_sclk = 1'b0;
    #(n * 5 - 40) o_cs_n = 1'b1;
    #80;
  endtask
endmodule

// ---- verif/predriver_status_readout_tb_top.sv ----
/* self-checking bench for the predriver status readout.
   assumes the host model and the bound checker sit beside it. */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module predriver_status_readout_tb_top;
  import predrv_status_pkg::*;
  logic       i_mclk, i_srst, cs_n, sclk, mosi, miso, irq, oc, sup, full_on, dsi;
  logic [2:0] ot, ds, hs, ls, node;
  logic [7:0] dt, r;
  int         error_cnt, check_count, cyc;
  spi_host_model host (.i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  predriver_status_readout DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_spi_cs_n(cs_n),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .i_overtemperature_detector(ot),
    .i_desaturation_detect(ds), .i_gate_supply_low(sup), .i_overcurrent(oc),
    .i_hs_on(hs), .i_ls_on(ls), .i_phase_switch_node(node), .o_spi_miso(miso),
    .o_irq(irq), .o_applied_deadtime(dt), .o_full_on_mode(full_on), .o_desaturation_detect_ignore(dsi));
  // time-base clock and hang guard
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic cmd(input logic [7:0] c);
    host.xfer(c, 8, r);
    settle(1);
  endtask
  // select a status register, then fetch it in the following frame
  task automatic rd(input logic [1:0] s, output logic [7:0] v);
    cmd({6'h00, s});
    host.xfer(8'h00, 8, v);
    settle(1);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] v;
    `CHK(dt, 8'hff)
    `CHK(irq, 1'b1)
    rd(SEL_MODE_BITS, v);
    `CHK(v, 8'h00)
    rd(SEL_IRQ_ENABLES, v);
    `CHK(v, 8'hff)
    rd(SEL_DEADTIME, v);
    `CHK(v, 8'h00)
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h80)
    host.xfer(8'h78, 8, v);
    `CHK(v, 8'h80)
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h00)
    `CHK(irq, 1'b0)
  endtask
  // each source latches, survives a clear while active, clears once gone
  task automatic t_faults();
    logic [7:0] v;
    for (int b = 0; b < 4; b++) begin
      {oc, sup, ds[1], ot[2]} = 4'h8 >> b;
      settle(10);
      `CHK(irq, 1'b1)
      cmd(8'h60 | (8'h08 >> b));
      rd(SEL_FAULT_LATCH, v);
      `CHK(v, 8'h08 >> b)
      {oc, sup, ds[1], ot[2]} = 4'h0;
      settle(10);
      rd(SEL_FAULT_LATCH, v);
      `CHK(v, 8'h08 >> b)
      cmd(8'h60 | (8'h08 >> b));
      rd(SEL_FAULT_LATCH, v);
      `CHK(v, 8'h00)
    end
  endtask
  task automatic t_mask();
    logic [7:0] v;
    cmd(8'h20);
    rd(SEL_IRQ_ENABLES, v);
    `CHK(v, 8'hf0)
    oc = 1'b1;
    settle(10);
    `CHK(irq, 1'b0)
    oc = 1'b0;
    cmd(8'h68);
    cmd(8'h2f);
    rd(SEL_IRQ_ENABLES, v);
    `CHK(v, 8'hff)
  endtask
  // short frame, then an undefined code
  task automatic t_errors();
    logic [7:0] v;
    host.xfer(8'h00, 0, v);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h20)
    host.xfer(8'h00, 7, v);
    cmd(8'hf0);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h60)
    cmd(8'h76);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_deadtime();
    logic [7:0] v;
    cmd(8'h80);
    `CHK(dt, 8'h00)
    rd(SEL_MODE_BITS, v);
    `CHK(v, 8'h28)
    rd(SEL_DEADTIME, v);
    `CHK(v, 8'h00)
    cmd(8'h81);
    host.cal(4200);
    settle(2);
    `CHK(dt, 8'hff)
    rd(SEL_MODE_BITS, v);
    `CHK(v, 8'h18)
    cmd(8'h81);
    host.cal(328);
    settle(2);
    `CHK(dt, 8'h14)
    rd(SEL_DEADTIME, v);
    `CHK(v, 8'h14)
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h20)
    cmd(8'h72);
  endtask
  // high side on: node following is fine, node stuck low is an error
  task automatic t_phase();
    logic [7:0] v;
    hs = 3'b001;
    settle(300);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h00)
    hs = 3'b000;
    node = 3'b000;
    settle(50);
    hs = 3'b001;
    settle(300);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h12)
    hs = 3'b000;
    cmd(8'h62);
    cmd(8'h71);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h00)
  endtask
  // after locking, settings writes and clears are refused and flagged
  task automatic t_lock();
    logic [7:0] v;
    cmd(8'h42);
    `CHK(full_on, 1'b1)
    rd(SEL_MODE_BITS, v);
    `CHK(v, 8'h0a)
    cmd(8'h49);
    `CHK(full_on, 1'b0)
    rd(SEL_MODE_BITS, v);
    `CHK(v, 8'h49)
    `CHK(dsi, 1'b1)
    cmd(8'h20);
    cmd(8'h80);
    cmd(8'h40);
    `CHK(dsi, 1'b1)
    rd(SEL_IRQ_ENABLES, v);
    `CHK(v, 8'hff)
    `CHK(dt, 8'h14)
    cmd(8'h74);
    rd(SEL_FAULT_LATCH, v);
    `CHK(v, 8'h40)
  endtask
  ////////////////////////////////////////
  initial begin
    {i_srst, oc, sup} = 3'b100;
    {ot, ds, hs, ls} = 12'h000;
    node = 3'b111;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    settle(12);
    i_srst = 1'b0;
    settle(6);
    t_reset();
    t_faults();
    t_mask();
    t_errors();
    t_deadtime();
    t_phase();
    t_lock();
    stop_test();
  end
endmodule
